// >>> verification/spas_host_model.sv
// host bus master model for both port modes
`timescale 1ns/1ps
module spas_host_model (
	output logic sclk, // serial clock
	output logic sda, // data, 1 = released
	output logic csN, // four-wire select
	input wire logic sdaOe, // device pulls data
	input wire logic doutOe // device pulls output
);
	localparam int T = 200;
	initial begin
		sclk = 1'b1;
		sda = 1'b1;
		csN = 1'b1;
	end
	// host alone makes the clock, idle high between frames
	task automatic twStart;
		sda <= 1'b0;
		#T sclk <= 1'b0;
	endtask : twStart
	task automatic twByte(input logic [7:0] b, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			#40 sda <= b[i];
			#T sclk <= 1'b1;
			#T sclk <= 1'b0;
		end
		#40 sda <= 1'b1;
		#T sclk <= 1'b1;
		#100 ak = sdaOe;
		#100 sclk <= 1'b0;
	endtask : twByte
	// host keeps data released and reads the pin in mid-high; declines more bytes
	task automatic twRead(output logic [7:0] d, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			#40 sda <= 1'b1;
			#T sclk <= 1'b1;
			#100 d[i] = sda & !sdaOe;
			#100 sclk <= 1'b0;
		end
		#40 sda <= 1'b1;
		#T sclk <= 1'b1;
		#100 ak = sdaOe;
		#100 sclk <= 1'b0;
	endtask : twRead
	task automatic twStop;
		#40 sda <= 1'b0;
		#T sclk <= 1'b1;
		#T sda <= 1'b1;
	endtask : twStop
	task automatic fwByte(input logic [7:0] b, output logic [7:0] q);
		csN <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#24 sclk <= 1'b0;
			sda <= b[i];
			#24 sclk <= 1'b1;
			q[i] = !doutOe;
		end
		#24 csN <= 1'b1;
		sda <= 1'b1;
	endtask : fwByte
endmodule : spas_host_model

// >>> verification/spas_port_properties.sv
// port-level assertions for the serial port block
`timescale 1ns/1ps
module spas_port_properties
	import spas_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst, // reset
	input wire logic csN, // select
	input wire logic [1:0] addLevel, // pin level
	input wire logic sdaOut, // data drive
	input wire logic sdaOe, // data pull
	input wire logic doutOut, // out drive
	input wire logic doutOe, // out pull
	input wire logic rxValid, // byte pulse
	input wire logic [6:0] busAddr, // address
	input wire logic addrLocked, // captured
	input wire logic fourWire // mode lock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [6:0] decAddr;
	assign decAddr = addLevel == LVL_LOW ? ADDR_PIN_LOW :
		addLevel == LVL_HIGH ? ADDR_PIN_HIGH : ADDR_PIN_FLOAT;
	a_open_drain: assert property (!sdaOut && !doutOut)
		else $error("pins driven high");
	a_dout_frame: assert property (csN |-> !doutOe)
		else $error("output pulled outside frame");
	a_mode_lock: assert property (fourWire |=> fourWire)
		else $error("mode lock lost");
	a_two_off: assert property (fourWire |-> !sdaOe)
		else $error("two-wire answer after lock");
	a_addr_frozen: assert property (addrLocked |=> addrLocked && $stable(busAddr))
		else $error("captured address moved");
	a_addr_decode: assert property ($stable(addLevel) [*5] ##0 !addrLocked |-> busAddr == decAddr)
		else $error("address not decoded");
	a_capture_ack: assert property ($rose(addrLocked) |-> ##[1:10] sdaOe)
		else $error("capture without ack");
	a_rx_pulse: assert property (rxValid |=> !rxValid)
		else $error("byte pulse too long");
endmodule : spas_port_properties
bind spas_port spas_port_properties chk (.mclk, .rst, .csN, .addLevel, .sdaOut, .sdaOe,
	.doutOut, .doutOe, .rxValid, .busAddr, .addrLocked, .fourWire);

// >>> verification/spas_port_tb.sv
// self-checking bench for the serial port block
`timescale 1ns/1ps
module serial_port_address_select_tb;
	import spas_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addLevel = LVL_LOW;
	logic [7:0] txByte = 8'h00;
	logic txLoad = 1'b0;
	logic sclk, hostSda, csN, sdaOe, doutOe, rxValid, addrLocked, fourWire, ack;
	logic [7:0] rxByte, got;
	logic [6:0] busAddr;
	logic sdaDrv, doutDrv;
	int rxCount = 0;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #20 mclk = ~mclk;
	spas_host_model host (.sclk(sclk), .sda(hostSda), .csN(csN), .sdaOe(sdaOe), .doutOe(doutOe));
	spas_port dut (.mclk(mclk), .rst(rst), .sclk(sclk), .sdaIn(hostSda & ~sdaOe), .sdaOut(sdaDrv),
		.sdaOe(sdaOe), .csN(csN), .addLevel(addLevel), .doutOut(doutDrv), .doutOe(doutOe),
		.txByte(txByte), .txLoad(txLoad), .rxByte(rxByte), .rxValid(rxValid),
		.busAddr(busAddr), .addrLocked(addrLocked), .fourWire(fourWire));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask : idle
	// write with data ~a, data byte only when addressed
	task automatic xfer(input logic [7:0] a);
		logic dak;
		host.twStart();
		host.twByte(a, ack);
		if (ack) host.twByte(~a, dak);
		host.twStop();
		idle(4);
	endtask : xfer
	task automatic tDecode;
		for (int l = 0; l < 3; l++) begin
			addLevel <= l[1:0];
			idle(6);
			chk({1'b0, busAddr}, l == 0 ? 8'h48 : l == 1 ? 8'h4a : 8'h4b);
		end
	endtask : tDecode
	task automatic tCapture;
		addLevel <= LVL_LOW;
		idle(6);
		xfer(8'h94);
		chk(8'(ack), 8'h00);
		xfer(8'h90);
		chk(8'(ack), 8'h01);
		chk(rxByte, 8'h6f);
		chk(8'(addrLocked), 8'h00);
		xfer(8'h90);
		chk(8'(addrLocked), 8'h01);
	endtask : tCapture
	task automatic tFrozen;
		addLevel <= LVL_HIGH;
		idle(8);
		chk({1'b0, busAddr}, 8'h48);
		xfer(8'h96);
		chk(8'(ack), 8'h00);
		xfer(8'h90);
		chk(8'(ack), 8'h01);
	endtask : tFrozen
	task automatic tRead;
		logic nak;
		txByte <= 8'h5a;
		txLoad <= 1'b1;
		idle(1);
		txLoad <= 1'b0;
		idle(3);
		host.twStart();
		host.twByte(8'h91, ack);
		host.twRead(got, nak);
		host.twStop();
		idle(4);
		chk(8'(ack), 8'h01);
		chk(got, 8'h5a);
		chk(8'(nak), 8'h00);
	endtask : tRead
	task automatic tFour;
		int n;
		txByte <= 8'hc3;
		txLoad <= 1'b1;
		idle(1);
		txLoad <= 1'b0;
		idle(3);
		n = rxCount;
		host.fwByte(8'h96, got);
		chk(got, 8'hc3);
		idle(6);
		chk(rxByte, 8'h96);
		chk(8'(rxCount - n), 8'h01);
		chk(8'(fourWire), 8'h01);
		xfer(8'h90);
		chk(8'(ack), 8'h00);
		chk({6'h00, sdaDrv, doutDrv}, 8'h00);
	endtask : tFour
	// whole run is well under two thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rxValid === 1'b1) begin
			rxCount <= rxCount + 1;
		end
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		idle(5);
		rst <= 1'b0;
		idle(3);
		tDecode();
		tCapture();
		tFrozen();
		tRead();
		tFour();
		final_report();
	end
endmodule : serial_port_address_select_tb

// >>> verilog/spas_pkg.sv
// constants shared by the serial port address-select block
package spas_pkg;
	localparam logic [6:0] ADDR_PIN_LOW = 7'h48;   // 1001 000
	localparam logic [6:0] ADDR_PIN_FLOAT = 7'h4a; // 1001 010
	localparam logic [6:0] ADDR_PIN_HIGH = 7'h4b;  // 1001 011
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_FLOAT = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] CAPTURE_MATCHES = 2'h2;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [2:0] FW_LAST_BIT = 3'h7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		SPAS_IDLE,
		SPAS_ADDR,
		SPAS_ACK,
		SPAS_WDATA,
		SPAS_RDATA,
		SPAS_RACK
	} spas_state_t;

	function automatic logic [6:0] spasDecode(input logic [1:0] lvl);
		case (lvl)
			LVL_LOW: spasDecode = ADDR_PIN_LOW;
			LVL_HIGH: spasDecode = ADDR_PIN_HIGH;
			default: spasDecode = ADDR_PIN_FLOAT;
		endcase
	endfunction : spasDecode
endpackage : spas_pkg

// >>> verilog/spas_port.sv
// shared two-wire / four-wire serial port with address-select capture
// Operation
// RULE1: four-wire output changes on falling clock
// RULE2: four-wire input sampled on rising clock
// RULE3: select pin level picks one of three addresses
// RULE4: address captured on eighth clock, second match
// RULE5: after capture select pin changes are ignored
// RULE6: host serial clock times every transfer
// RULE7: host frames four-wire transfers with chip select
// RULE8: two-wire after power-up, four-wire locks
// RULE9: received address compared with active address
`timescale 1ns/1ps
module spas_port (
	input wire logic mclk,                       // system clock
	input wire logic rst,                        // reset, high; synchronous in the mclk domain, asynchronous for fwWord and fwTog
	input wire logic sclk,                       // serial clock pin, link domain
	input wire logic sdaIn,                      // data pin level
	output logic sdaOut,                         // data pin drive value
	output logic sdaOe,                          // data pin pulls low when high
	input wire logic csN,                        // four-wire chip select, low
	input wire logic [1:0] addLevel,             // select pin level detector
	output logic doutOut,                        // four-wire output drive value
	output logic doutOe,                         // four-wire output pulls low
	input wire logic [7:0] txByte,               // byte the device returns
	input wire logic txLoad,                     // take txByte
	output logic [7:0] rxByte,                   // last received byte
	output logic rxValid,                        // one-cycle pulse with rxByte
	output logic [6:0] busAddr,                  // active two-wire address
	output logic addrLocked,                     // address captured
	output logic fourWire                        // four-wire mode locked
);
	import spas_pkg::*;

	// ---------------- link domain, four-wire ----------------
	logic [7:0] fwShift;
	logic [7:0] fwWord;
	logic [2:0] fwCnt;
	logic fwTog;
	logic [7:0] next_fwShift;
	logic [7:0] next_fwWord;
	logic [2:0] next_fwCnt;
	logic next_fwTog;
	logic [2:0] fwOutIdx;
	logic [7:0] txHold;

	always_comb begin
		next_fwShift = {fwShift[6:0], sdaIn}; // [RULE2]
		next_fwCnt = fwCnt + 3'h1;
		next_fwWord = fwWord;
		next_fwTog = fwTog;
		if (fwCnt == FW_LAST_BIT) begin
			next_fwWord = next_fwShift;
			next_fwTog = ~fwTog;
		end
	end

	// chip select high clears the frame; the link clock may stop between frames
	always_ff @(posedge sclk or posedge csN) begin // [RULE6] [RULE7]
		if (csN) begin
			fwShift <= RESET_BYTE;
			fwCnt <= 3'h0;
		end else begin
			fwShift <= next_fwShift;
			fwCnt <= next_fwCnt;
		end
	end

	// word and toggle survive the frame end so the system side can still take them
	// rst clears them: a toggle left unknown would never be seen to change
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			fwWord <= RESET_BYTE;
			fwTog <= 1'b0;
		end else begin
			fwWord <= next_fwWord;
			fwTog <= next_fwTog;
		end
	end

	// txHold only changes while chip select is high, so it is static in a frame
	always_ff @(negedge sclk or posedge csN) begin // [RULE1]
		if (csN) begin
			fwOutIdx <= 3'h0;
			doutOe <= 1'b0;
		end else begin
			doutOe <= ~txHold[3'h7 - fwOutIdx];
			fwOutIdx <= fwOutIdx + 3'h1;
		end
	end

	// ---------------- system domain ----------------
	logic sclS;
	logic sdaS;
	logic csNS;
	logic fwTogS;
	logic [1:0] addS;
	logic sclSn;
	logic sdaSn;
	logic csSel;

	// pins cross inverted so the cleared synchroniser reads as an idle bus;
	// otherwise a low chip select right after reset would lock four-wire mode
	spas_sync #(.W(6)) u_sync (
		.clk(mclk),
		.rst(rst),
		.d({~sclk, ~sdaIn, ~csN, fwTog, addLevel}),
		.q({sclSn, sdaSn, csSel, fwTogS, addS})
	);
	assign sclS = ~sclSn;
	assign sdaS = ~sdaSn;
	assign csNS = ~csSel;

	logic sclQ;
	logic sdaQ;
	logic fwTogQ;
	spas_state_t state;
	spas_state_t next_state;
	spas_state_t ackReturn;
	spas_state_t next_ackReturn;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [1:0] matchCnt;
	logic [1:0] next_matchCnt;
	logic [6:0] lockedAddr;
	logic [6:0] next_lockedAddr;
	logic next_addrLocked;
	logic next_fourWire;
	logic next_sdaOe;
	logic [7:0] next_rxByte;
	logic next_rxValid;
	logic [7:0] next_txHold;
	logic [6:0] activeAddr;
	logic [7:0] shIn;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclRise = sclS & ~sclQ;
	assign sclFall = ~sclS & sclQ;
	assign startCond = sclS & sclQ & sdaQ & ~sdaS;
	assign stopCond = sclS & sclQ & ~sdaQ & sdaS;
	assign shIn = {sh[6:0], sdaS};
	assign activeAddr = addrLocked ? lockedAddr : spasDecode(addS); // [RULE3] [RULE5]

	always_comb begin
		next_state = state;
		next_ackReturn = ackReturn;
		next_cnt = cnt;
		next_sh = sh;
		next_matchCnt = matchCnt;
		next_lockedAddr = lockedAddr;
		next_addrLocked = addrLocked;
		next_fourWire = fourWire | ~csNS; // [RULE8]
		next_sdaOe = sdaOe;
		next_rxByte = rxByte;
		next_rxValid = 1'b0;
		next_txHold = txHold;
		if (txLoad && csNS) begin
			next_txHold = txByte;
		end
		if (fwTogS != fwTogQ) begin
			next_rxByte = fwWord;
			next_rxValid = 1'b1;
		end
		// start and stop win over every state, so a cut frame simply restarts
		if (fourWire || !csNS) begin // [RULE8]
			next_state = SPAS_IDLE; // two-wire side stays silent once locked
			next_sdaOe = 1'b0;
		end else if (startCond) begin
			next_state = SPAS_ADDR;
			next_cnt = 4'h0;
			next_sdaOe = 1'b0;
		end else if (stopCond) begin
			next_state = SPAS_IDLE;
			next_sdaOe = 1'b0;
		end else begin
			case (state)
				SPAS_IDLE: begin
					next_sdaOe = 1'b0;
				end
				SPAS_ADDR: begin
					if (sclRise) begin
						next_sh = shIn;
						next_cnt = cnt + 4'h1;
						if (cnt == LAST_BIT) begin
							if (shIn[7:1] == activeAddr) begin // [RULE9]
								next_ackReturn = shIn[0] ? SPAS_RDATA : SPAS_WDATA;
								next_state = SPAS_ACK;
								// counted only while unlocked; a mismatch keeps the count
								if (!addrLocked) begin
									next_matchCnt = matchCnt + 2'h1;
									if (matchCnt + 2'h1 == CAPTURE_MATCHES) begin // [RULE4]
										next_addrLocked = 1'b1;
										next_lockedAddr = shIn[7:1];
									end
								end
							end else begin
								next_state = SPAS_IDLE;
							end
						end
					end
				end
				SPAS_ACK: begin
					// first fall after the byte pulls low; the next fall releases for a write, or drives the first data bit for a read
					if (sclFall) begin
						if (!sdaOe) begin
							next_sdaOe = 1'b1;
						end else if (ackReturn == SPAS_RDATA) begin
							next_state = SPAS_RDATA;
							next_sdaOe = ~txHold[7];
							next_cnt = 4'h1;
						end else begin
							next_state = SPAS_WDATA;
							next_sdaOe = 1'b0;
							next_cnt = 4'h0;
						end
					end
				end
				SPAS_WDATA: begin
					if (sclRise) begin
						next_sh = shIn;
						next_cnt = cnt + 4'h1;
						if (cnt == LAST_BIT) begin
							next_rxByte = shIn;
							next_rxValid = 1'b1;
							next_ackReturn = SPAS_WDATA;
							next_state = SPAS_ACK;
						end
					end
				end
				SPAS_RDATA: begin
					// bits only move after a fall, so the host never sees a false stop
					if (sclFall) begin
						if (cnt > LAST_BIT) begin
							next_sdaOe = 1'b0;
							next_state = SPAS_RACK;
						end else begin
							next_sdaOe = ~txHold[3'h7 - cnt[2:0]];
							next_cnt = cnt + 4'h1;
						end
					end
				end
				SPAS_RACK: begin
					// a host that answers low wants another byte
					// the repeated byte starts at the fall after the host's ack clock
					if (sclRise) begin
						next_state = sdaS ? SPAS_IDLE : SPAS_RDATA;
						next_cnt = 4'h0;
					end
				end
				default: begin
					next_state = SPAS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			fwTogQ <= 1'b0;
			state <= SPAS_IDLE;
			ackReturn <= SPAS_WDATA;
			cnt <= 4'h0;
			sh <= RESET_BYTE;
			matchCnt <= 2'h0;
			lockedAddr <= ADDR_PIN_FLOAT;
			addrLocked <= 1'b0;
			fourWire <= 1'b0;
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
			doutOut <= 1'b0;
			rxByte <= RESET_BYTE;
			rxValid <= 1'b0;
			txHold <= RESET_BYTE;
			busAddr <= ADDR_PIN_FLOAT;
		end else begin
			sclQ <= sclS;
			sdaQ <= sdaS;
			fwTogQ <= fwTogS;
			state <= next_state;
			ackReturn <= next_ackReturn;
			cnt <= next_cnt;
			sh <= next_sh;
			matchCnt <= next_matchCnt;
			lockedAddr <= next_lockedAddr;
			addrLocked <= next_addrLocked;
			fourWire <= next_fourWire;
			sdaOe <= next_sdaOe;
			sdaOut <= 1'b0;
			doutOut <= 1'b0;
			rxByte <= next_rxByte;
			rxValid <= next_rxValid;
			txHold <= next_txHold;
			busAddr <= activeAddr;
		end
	end
endmodule : spas_port

// >>> verilog/spas_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module spas_sync #(
	parameter int W = 1
) (
	input wire logic clk,       // destination clock
	input wire logic rst,       // synchronous reset, active high
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q      // synchronised levels
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : spas_sync
